// *** logic/spr_regs.svh ***
// Register indices, field positions and reset values of the two serial ports.
// Assumes byte address = 4 * index on a 32-bit Avalon-MM slave.
`ifndef SPR_REGS_SVH
`define SPR_REGS_SVH

// ----------------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------------
`define SPR_IDX_E_DATA 8'hc8
`define SPR_IDX_E_ADDR_ZERO 8'hc9
`define SPR_IDX_E_ADDR_ONE 8'hca
`define SPR_IDX_E_STATUS 8'hcb
`define SPR_IDX_F_DATA 8'hd8
`define SPR_IDX_F_ADDR_ZERO 8'hd9
`define SPR_IDX_F_ADDR_ONE 8'hda
`define SPR_IDX_F_STATUS 8'hdb
`define SPR_IDX_CTRL 8'he0
`define SPR_IDX_INT_STATUS 8'he1
`define SPR_IDX_INT_MASK 8'he2
`define SPR_IDX_LSB 2
`define SPR_IDX_MSB 9

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SPR_ST_RX_READY 7
`define SPR_ST_RX_ADDR 6
`define SPR_ST_OVERRUN 5
`define SPR_ST_TX_FULL 3
`define SPR_CTRL_HDLC_E 0
`define SPR_CTRL_HDLC_F 1
`define SPR_INT_RX 0
`define SPR_INT_TX_EMPTY 1
`define SPR_INT_OVERRUN 2
`define SPR_INT_F_BASE 4

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SPR_CTRL_RESET 8'h00
`define SPR_INT_MASK_RESET 8'h00
`define SPR_BYTE_ZERO 8'h00
`define SPR_WORD_ZERO 32'h0000_0000

`endif

// *** logic/spr_pkg.sv ***
// Types shared by the serial port register block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package spr_pkg;

    // How a transmit byte was written
    typedef enum logic [1:0] {
        spr_tag_data,
        spr_tag_addr_zero,
        spr_tag_addr_one
    } spr_tag_t;

    // Byte handed to the transmitter
    typedef struct packed {
        logic [7:0] data;
        spr_tag_t tag;
        logic frame_end;
        logic send_crc;
    } spr_tx_t;

    // Byte offered by the receiver
    typedef struct packed {
        logic [7:0] data;
        logic addr_bit;
    } spr_rx_t;

endpackage

`default_nettype wire

// *** logic/spr_irq.sv ***
// Sticky interrupt status with write-one-to-clear, a mask and one level output.
// Assumes set and clear strobes come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "spr_regs.svh"

module spr_irq #(
    parameter int WIDTH = 8
) (
    input wire logic clk, // System clock
    input wire logic reset, // Synchronous reset
    input wire logic [WIDTH-1:0] set_ev, // Event pulses
    input wire logic [WIDTH-1:0] hw_clr, // Clears from the ports
    input wire logic w1c_en, // Status write strobe
    input wire logic [WIDTH-1:0] w1c_data, // Ones clear bits
    input wire logic mask_wr, // Mask write strobe
    input wire logic [WIDTH-1:0] mask_data, // New mask
    output logic [WIDTH-1:0] status_r, // Sticky status
    output logic [WIDTH-1:0] mask_r, // Mask register
    output logic irq // Level interrupt
);

    logic [WIDTH-1:0] clr;

    assign clr = hw_clr | (w1c_en ? w1c_data : '0);

    // Set wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            status_r <= '0;
        end else begin
            status_r <= (status_r & ~clr) | set_ev;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            mask_r <= WIDTH'(`SPR_INT_MASK_RESET);
        end else if (mask_wr) begin
            mask_r <= mask_data;
        end
    end

    assign irq = |(status_r & mask_r);

endmodule

`default_nettype wire

// *** logic/spr_port.sv ***
// One serial port: receive buffer, transmit buffer, status and receive interrupt.
// Assumes the transmitter and receiver run on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "spr_regs.svh"

module spr_port (
    input wire logic clk, // System clock
    input wire logic reset, // Synchronous reset
    input wire logic hdlc_mode, // One for HDLC, zero for async
    input wire logic wr_en, // Transmit buffer write
    input wire spr_pkg::spr_tag_t wr_tag, // Which register was written
    input wire logic [7:0] wr_data, // Written byte
    input wire logic rd_buf, // Receive buffer read accepted
    input wire logic rx_hold, // Freeze receive buffer during a read
    input wire logic st_wr, // Status register written
    output spr_pkg::spr_tx_t tx, // Byte to transmitter
    output logic tx_valid, // Transmit byte waiting
    input wire logic tx_ready, // Transmitter takes byte
    input wire spr_pkg::spr_rx_t rx, // Byte from receiver
    input wire logic rx_valid, // Receiver has a byte
    output logic rx_ready, // Buffer takes byte
    input wire logic rx_overrun, // Receiver lost a byte
    output logic [7:0] rx_buf, // Receive buffer contents
    output logic [7:0] status, // Status byte
    output logic rx_irq_ff, // Receiver interrupt flip-flop
    output logic ev_rx, // Byte loaded into buffer
    output logic ev_tx_empty // Transmit buffer emptied
);

    spr_pkg::spr_rx_t rx_r;
    spr_pkg::spr_tx_t tx_r;
    logic rx_full_r;
    logic ovr_r;
    logic irq_r;
    logic tx_full_r;
    logic rx_load;
    logic tx_drop;

    // A read frees the buffer in the same cycle, so the next byte moves in at once
    assign rx_ready = !rx_hold && (!rx_full_r || rd_buf);
    assign rx_load = rx_valid && rx_ready;
    assign tx_drop = tx_full_r && !wr_en && ((tx_valid && tx_ready) || st_wr);

    always_ff @(posedge clk) begin
        if (reset) begin
            rx_r <= '0;
            rx_full_r <= 1'b0;
        end else if (rx_load) begin
            rx_r <= rx;
            rx_full_r <= 1'b1;
        end else if (rd_buf) begin
            rx_full_r <= 1'b0;
        end
    end

    // Load sets, read clears; a reload on the read cycle keeps it set
    always_ff @(posedge clk) begin
        if (reset) begin
            irq_r <= 1'b0;
        end else if (rx_load) begin
            irq_r <= 1'b1;
        end else if (rd_buf) begin
            irq_r <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ovr_r <= 1'b0;
        end else if (rx_overrun) begin
            ovr_r <= 1'b1;
        end else if (rd_buf) begin
            ovr_r <= 1'b0;
        end
    end

    // A write while full overwrites the waiting byte
    always_ff @(posedge clk) begin
        if (reset) begin
            tx_r <= '0;
            tx_full_r <= 1'b0;
        end else if (wr_en) begin
            tx_r.data <= wr_data;
            tx_r.tag <= wr_tag;
            tx_r.frame_end <= hdlc_mode && (wr_tag != spr_pkg::spr_tag_data);
            tx_r.send_crc <= hdlc_mode && (wr_tag == spr_pkg::spr_tag_addr_zero);
            tx_full_r <= 1'b1;
        end else if (tx_drop) begin
            tx_full_r <= 1'b0;
        end
    end

    assign tx = tx_r;
    assign tx_valid = tx_full_r;
    assign rx_buf = rx_r.data;
    assign rx_irq_ff = irq_r;
    assign ev_rx = rx_load;
    assign ev_tx_empty = tx_drop;

    always_comb begin
        status = `SPR_BYTE_ZERO;
        status[`SPR_ST_RX_READY] = rx_full_r;
        status[`SPR_ST_RX_ADDR] = rx_r.addr_bit;
        status[`SPR_ST_OVERRUN] = ovr_r;
        status[`SPR_ST_TX_FULL] = tx_full_r;
    end

endmodule

`default_nettype wire

// *** logic/spr_top.sv ***
// Register block of serial ports E and F on an Avalon-MM slave with waitrequest.
// Assumes one clock for bus, transmitters and receivers; receivers bring their own FIFO.
//
// What this block does
// - Reading the data, address-zero or address-one register returns the port's receive byte.
// - Writing the data register loads the transmit buffer with a plain data byte.
// - Writing the address-zero register loads the transmit buffer as an address byte with bit 0.
// - In HDLC mode a last byte written as address-zero ends the frame with CRC and flag.
// - Writing the address-one register loads the transmit buffer as an address byte with bit 1.
// - In HDLC mode a last byte written as address-one ends the frame with a flag and no CRC.
// - Status bit 7 is one while a received byte waits in the buffer, else zero.
// - A byte arriving in the receive buffer sets the receiver interrupt flip-flop.
// - Reading the receive buffer clears the receiver interrupt flip-flop.
// - When more bytes wait, a read moves the next one in and sets the flip-flop again.
// - Status bit 3 sets on a transmit write, clears on hand-off or status write, and its fall interrupts.
// - Status bit 5 flags a receive overrun and clears when the buffer is read.
`timescale 1ns/1ps
`default_nettype none
`include "spr_regs.svh"

module spr_top (
    input wire logic clk, // 40 MHz system clock
    input wire logic reset, // Synchronous, active high
    input wire logic [9:0] address, // Avalon byte address
    input wire logic read, // Avalon read
    input wire logic write, // Avalon write
    input wire logic [31:0] writedata, // Avalon write data
    input wire logic [3:0] byteenable, // Avalon byte enables
    output logic [31:0] readdata, // Avalon read data
    output logic waitrequest, // Avalon wait
    output logic irq, // Level interrupt
    output spr_pkg::spr_tx_t tx_e, // Port E byte to transmitter
    output logic tx_e_valid, // Port E byte waiting
    input wire logic tx_e_ready, // Port E transmitter takes it
    input wire spr_pkg::spr_rx_t rx_e, // Port E byte from receiver
    input wire logic rx_e_valid, // Port E receiver has byte
    output logic rx_e_ready, // Port E buffer takes byte
    input wire logic rx_e_overrun, // Port E receiver lost a byte
    output spr_pkg::spr_tx_t tx_f, // Port F byte to transmitter
    output logic tx_f_valid, // Port F byte waiting
    input wire logic tx_f_ready, // Port F transmitter takes it
    input wire spr_pkg::spr_rx_t rx_f, // Port F byte from receiver
    input wire logic rx_f_valid, // Port F receiver has byte
    output logic rx_f_ready, // Port F buffer takes byte
    input wire logic rx_f_overrun // Port F receiver lost a byte
);

    // ------------------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------------------
    // Every access takes exactly one wait state: read data is captured in the
    // first cycle and the access takes effect at the edge of the second.
    logic ack_r;
    logic req;
    logic accept;
    logic wr_ok;
    logic rd_ok;
    logic [7:0] idx;
    logic [31:0] readdata_r;
    logic [31:0] rd_mux;

    assign req = read || write;
    assign accept = req && ack_r;
    assign waitrequest = req && !ack_r;
    assign idx = address[`SPR_IDX_MSB:`SPR_IDX_LSB];
    assign wr_ok = accept && write && byteenable[0];
    assign rd_ok = accept && read;
    assign readdata = readdata_r;

    always_ff @(posedge clk) begin
        if (reset) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req && !ack_r;
        end
    end

    // ------------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------------
    logic e_tx_sel;
    logic f_tx_sel;
    logic e_buf_sel;
    logic f_buf_sel;
    spr_pkg::spr_tag_t e_tag;
    spr_pkg::spr_tag_t f_tag;

    always_comb begin
        e_buf_sel = 1'b1;
        e_tag = spr_pkg::spr_tag_data;
        case (idx)
            `SPR_IDX_E_DATA: e_tag = spr_pkg::spr_tag_data;
            `SPR_IDX_E_ADDR_ZERO: e_tag = spr_pkg::spr_tag_addr_zero;
            `SPR_IDX_E_ADDR_ONE: e_tag = spr_pkg::spr_tag_addr_one;
            default: e_buf_sel = 1'b0;
        endcase
    end

    always_comb begin
        f_buf_sel = 1'b1;
        f_tag = spr_pkg::spr_tag_data;
        case (idx)
            `SPR_IDX_F_DATA: f_tag = spr_pkg::spr_tag_data;
            `SPR_IDX_F_ADDR_ZERO: f_tag = spr_pkg::spr_tag_addr_zero;
            `SPR_IDX_F_ADDR_ONE: f_tag = spr_pkg::spr_tag_addr_one;
            default: f_buf_sel = 1'b0;
        endcase
    end

    assign e_tx_sel = wr_ok && e_buf_sel;
    assign f_tx_sel = wr_ok && f_buf_sel;

    // ------------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------------
    logic [7:0] ctrl_r;

    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_r <= `SPR_CTRL_RESET;
        end else if (wr_ok && idx == `SPR_IDX_CTRL) begin
            ctrl_r <= writedata[7:0];
        end
    end

    // ------------------------------------------------------------------------
    // Ports
    // ------------------------------------------------------------------------
    logic [7:0] e_rx_buf;
    logic [7:0] f_rx_buf;
    logic [7:0] e_status;
    logic [7:0] f_status;
    logic e_rx_irq;
    logic f_rx_irq;
    logic e_ev_rx;
    logic f_ev_rx;
    logic e_ev_tx;
    logic f_ev_tx;
    logic e_rd;
    logic f_rd;
    logic e_st_wr;
    logic f_st_wr;

    // Loads are frozen while a buffer read waits, so captured data stays true
    assign e_rd = rd_ok && e_buf_sel;
    assign f_rd = rd_ok && f_buf_sel;
    assign e_st_wr = wr_ok && idx == `SPR_IDX_E_STATUS;
    assign f_st_wr = wr_ok && idx == `SPR_IDX_F_STATUS;

    spr_port u_port_e (
        .clk(clk),
        .reset(reset),
        .hdlc_mode(ctrl_r[`SPR_CTRL_HDLC_E]),
        .wr_en(e_tx_sel),
        .wr_tag(e_tag),
        .wr_data(writedata[7:0]),
        .rd_buf(e_rd),
        .rx_hold(waitrequest && read && e_buf_sel),
        .st_wr(e_st_wr),
        .tx(tx_e),
        .tx_valid(tx_e_valid),
        .tx_ready(tx_e_ready),
        .rx(rx_e),
        .rx_valid(rx_e_valid),
        .rx_ready(rx_e_ready),
        .rx_overrun(rx_e_overrun),
        .rx_buf(e_rx_buf),
        .status(e_status),
        .rx_irq_ff(e_rx_irq),
        .ev_rx(e_ev_rx),
        .ev_tx_empty(e_ev_tx)
    );

    spr_port u_port_f (
        .clk(clk),
        .reset(reset),
        .hdlc_mode(ctrl_r[`SPR_CTRL_HDLC_F]),
        .wr_en(f_tx_sel),
        .wr_tag(f_tag),
        .wr_data(writedata[7:0]),
        .rd_buf(f_rd),
        .rx_hold(waitrequest && read && f_buf_sel),
        .st_wr(f_st_wr),
        .tx(tx_f),
        .tx_valid(tx_f_valid),
        .tx_ready(tx_f_ready),
        .rx(rx_f),
        .rx_valid(rx_f_valid),
        .rx_ready(rx_f_ready),
        .rx_overrun(rx_f_overrun),
        .rx_buf(f_rx_buf),
        .status(f_status),
        .rx_irq_ff(f_rx_irq),
        .ev_rx(f_ev_rx),
        .ev_tx_empty(f_ev_tx)
    );

    // ------------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------------
    // The rx bit follows the port flip-flop: set on a load, cleared by a read.
    logic [7:0] int_set;
    logic [7:0] int_clr;
    logic [7:0] int_status;
    logic [7:0] int_mask;

    always_comb begin
        int_set = `SPR_BYTE_ZERO;
        int_clr = `SPR_BYTE_ZERO;
        int_set[`SPR_INT_RX] = e_ev_rx;
        int_set[`SPR_INT_TX_EMPTY] = e_ev_tx;
        int_set[`SPR_INT_OVERRUN] = rx_e_overrun;
        int_set[`SPR_INT_F_BASE + `SPR_INT_RX] = f_ev_rx;
        int_set[`SPR_INT_F_BASE + `SPR_INT_TX_EMPTY] = f_ev_tx;
        int_set[`SPR_INT_F_BASE + `SPR_INT_OVERRUN] = rx_f_overrun;
        int_clr[`SPR_INT_RX] = e_rd;
        int_clr[`SPR_INT_TX_EMPTY] = e_tx_sel || e_st_wr;
        int_clr[`SPR_INT_F_BASE + `SPR_INT_RX] = f_rd;
        int_clr[`SPR_INT_F_BASE + `SPR_INT_TX_EMPTY] = f_tx_sel || f_st_wr;
    end

    spr_irq #(
        .WIDTH(8)
    ) u_irq (
        .clk(clk),
        .reset(reset),
        .set_ev(int_set),
        .hw_clr(int_clr),
        .w1c_en(wr_ok && idx == `SPR_IDX_INT_STATUS),
        .w1c_data(writedata[7:0]),
        .mask_wr(wr_ok && idx == `SPR_IDX_INT_MASK),
        .mask_data(writedata[7:0]),
        .status_r(int_status),
        .mask_r(int_mask),
        .irq(irq)
    );

    // ------------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------------
    always_comb begin
        rd_mux = `SPR_WORD_ZERO;
        case (idx)
            `SPR_IDX_E_DATA, `SPR_IDX_E_ADDR_ZERO, `SPR_IDX_E_ADDR_ONE: begin
                rd_mux[7:0] = e_rx_buf;
            end
            `SPR_IDX_F_DATA, `SPR_IDX_F_ADDR_ZERO, `SPR_IDX_F_ADDR_ONE: begin
                rd_mux[7:0] = f_rx_buf;
            end
            `SPR_IDX_E_STATUS: rd_mux[7:0] = e_status;
            `SPR_IDX_F_STATUS: rd_mux[7:0] = f_status;
            `SPR_IDX_CTRL: rd_mux[7:0] = ctrl_r;
            `SPR_IDX_INT_STATUS: rd_mux[7:0] = int_status;
            `SPR_IDX_INT_MASK: rd_mux[7:0] = int_mask;
            default: rd_mux = `SPR_WORD_ZERO;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            readdata_r <= `SPR_WORD_ZERO;
        end else if (waitrequest && read) begin
            readdata_r <= rd_mux;
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_bus_one_wait: assert property (waitrequest ##1 req |-> !waitrequest)
        else $error("bus access waited more than one cycle");

    a_read_buffer_e: assert property (
        (rd_ok && e_buf_sel) |-> readdata[7:0] == e_rx_buf && readdata[31:8] == 24'h00_0000)
        else $error("port e buffer read returned wrong byte");

    a_read_buffer_f: assert property (
        (rd_ok && f_buf_sel) |-> readdata[7:0] == f_rx_buf)
        else $error("port f buffer read returned wrong byte");

    a_write_data_tag: assert property (
        (wr_ok && idx == `SPR_IDX_E_DATA) |=>
            tx_e_valid && tx_e.tag == spr_pkg::spr_tag_data && !tx_e.frame_end
            && tx_e.data == $past(writedata[7:0]))
        else $error("data write did not load a plain byte");

    a_write_addr_zero: assert property (
        (wr_ok && idx == `SPR_IDX_E_ADDR_ZERO) |=>
            tx_e_valid && tx_e.tag == spr_pkg::spr_tag_addr_zero)
        else $error("address-zero write lost its tag");

    a_hdlc_end_crc: assert property (
        (wr_ok && idx == `SPR_IDX_E_ADDR_ZERO && ctrl_r[`SPR_CTRL_HDLC_E]) |=>
            tx_e.frame_end && tx_e.send_crc)
        else $error("frame end with crc not marked");

    a_write_addr_one: assert property (
        (wr_ok && idx == `SPR_IDX_F_ADDR_ONE) |=>
            tx_f_valid && tx_f.tag == spr_pkg::spr_tag_addr_one)
        else $error("address-one write lost its tag");

    a_hdlc_end_nocrc: assert property (
        (wr_ok && idx == `SPR_IDX_F_ADDR_ONE && ctrl_r[`SPR_CTRL_HDLC_F]) |=>
            tx_f.frame_end && !tx_f.send_crc)
        else $error("frame end without crc not marked");

    a_rx_ready_bit: assert property (
        (rx_e_valid && rx_e_ready) |=> e_status[`SPR_ST_RX_READY] && e_rx_buf == $past(rx_e.data))
        else $error("receive ready bit not set on load");

    a_rx_irq_set: assert property (
        (!e_status[`SPR_ST_RX_READY] && rx_e_valid && rx_e_ready) |=> e_rx_irq ##0 irq || !int_mask[`SPR_INT_RX])
        else $error("receive interrupt flip-flop not set");

    a_rx_irq_clear: assert property (
        (e_rd && !rx_e_valid) |=> !e_rx_irq && !e_status[`SPR_ST_RX_READY])
        else $error("buffer read did not clear receive interrupt");

    a_rx_irq_reload: assert property (
        (e_rd && rx_e_valid) |-> rx_e_ready ##1 (e_rx_irq && e_status[`SPR_ST_RX_READY]))
        else $error("waiting byte not moved in after read");

    a_tx_full_flag: assert property (
        (e_tx_sel |=> e_status[`SPR_ST_TX_FULL])
        and ((e_st_wr && !e_tx_sel) |=> !e_status[`SPR_ST_TX_FULL]
            && int_status[`SPR_INT_TX_EMPTY] == $past(e_status[`SPR_ST_TX_FULL])))
        else $error("transmit full flag or its interrupt wrong");

    a_overrun_flag: assert property (
        (rx_e_overrun |=> e_status[`SPR_ST_OVERRUN])
        and ((e_rd && !rx_e_overrun) |=> !e_status[`SPR_ST_OVERRUN]))
        else $error("overrun flag wrong");

    a_ports_apart: assert property (
        (e_tx_sel && !f_status[`SPR_ST_TX_FULL]) |=> !f_status[`SPR_ST_TX_FULL])
        else $error("write to port e reached port f");

    c_buffer_read: cover property (e_rd ##1 !e_status[`SPR_ST_RX_READY]);
    c_read_reload: cover property (e_rd && rx_e_valid);
    c_hdlc_crc_end: cover property (wr_ok && idx == `SPR_IDX_E_ADDR_ZERO && ctrl_r[`SPR_CTRL_HDLC_E]);
    c_irq_raised: cover property (!irq ##1 irq);

endmodule

`default_nettype wire

// *** verif/spr_far.sv ***
// Far-side station model: takes transmit bytes and offers received bytes.
// Assumes the bench sets stall and queues bytes through offer.
`timescale 1ns/1ps
`default_nettype none

module spr_far (
    input wire logic clk, // System clock
    input wire logic stall, // Holds off taking bytes
    input wire spr_pkg::spr_tx_t tx, // Byte from block
    input wire logic tx_valid, // Byte waiting
    output logic tx_ready, // Takes byte
    output spr_pkg::spr_rx_t rx, // Byte to block
    output logic rx_valid, // Byte offered
    input wire logic rx_ready, // Block takes byte
    output spr_pkg::spr_tx_t got // Last byte taken
);
    spr_pkg::spr_rx_t q[$];
    task automatic offer(input spr_pkg::spr_rx_t b);
        q.push_back(b);
    endtask
    initial begin
        rx = '0;
        rx_valid = 1'b0;
        got = '0;
    end
    assign tx_ready = ~stall;
    // Idle data toggles so a stale byte can never pass for a real one
    always @(posedge clk) begin
        if (tx_valid && tx_ready) got <= tx;
        if (rx_valid && rx_ready) q.delete(0);
        rx_valid <= q.size() != 0;
        rx <= (q.size() != 0) ? q[0] : ~rx;
    end
endmodule

`default_nettype wire

// *** verif/test_spr_top.sv ***
// Self-checking bench of the serial port register block.
// Assumes the design files and the far-side model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "spr_regs.svh"

module test_spr_top;
    logic clk = 0, reset = 1, read = 0, write = 0, stall_e = 1, stall_f = 1, ov_e = 0;
    logic waitrequest, irq, tv_e, tv_f, tr_e, tr_f, rv_e, rv_f, rr_e, rr_f;
    logic [9:0] address = '0;
    logic [31:0] writedata = '0, readdata, rd;
    logic [3:0] byteenable = 4'h1;
    spr_pkg::spr_tx_t tx_e, tx_f, got_e, got_f, ex;
    spr_pkg::spr_rx_t rx_e, rx_f;
    int err_total = 0, check_count = 0, cyc = 0;
    always #12.5 clk = ~clk;
    spr_top spr_top_i (.clk(clk), .reset(reset), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .irq(irq), .tx_e(tx_e), .tx_e_valid(tv_e),
        .tx_e_ready(tr_e), .rx_e(rx_e), .rx_e_valid(rv_e), .rx_e_ready(rr_e),
        .rx_e_overrun(ov_e), .tx_f(tx_f), .tx_f_valid(tv_f), .tx_f_ready(tr_f), .rx_f(rx_f),
        .rx_f_valid(rv_f), .rx_f_ready(rr_f), .rx_f_overrun(ov_e));
    spr_far spr_far_e_i (.clk(clk), .stall(stall_e), .tx(tx_e), .tx_valid(tv_e),
        .tx_ready(tr_e), .rx(rx_e), .rx_valid(rv_e), .rx_ready(rr_e), .got(got_e));
    spr_far spr_far_f_i (.clk(clk), .stall(stall_f), .tx(tx_f), .tx_valid(tv_f),
        .tx_ready(tr_f), .rx(rx_f), .rx_valid(rv_f), .rx_ready(rr_f), .got(got_f));
    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Request stands until waitrequest is sampled low; an idle edge follows
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        read <= ~wr;
        write <= wr;
        address <= {idx, 2'b00};
        writedata <= {24'h00_0000, wd};
        @(posedge clk);
        while (waitrequest !== 1'b0) @(posedge clk);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask
    task automatic t_tx;
        for (int h = 0; h < 2; h++) begin
            bus(1'b1, `SPR_IDX_CTRL, {6'h00, h[0], h[0]});
            for (int p = 0; p < 2; p++) begin
                for (int t = 0; t < 3; t++) begin
                    bus(1'b1, (p ? `SPR_IDX_F_DATA : `SPR_IDX_E_DATA) + t[7:0], 8'h50 + t[7:0]);
                    chk("other_tx_valid", 12'(p ? tv_e : tv_f), 12'h000);
                    bus(1'b0, p ? `SPR_IDX_F_STATUS : `SPR_IDX_E_STATUS, 8'h00);
                    chk("tx_full", 12'(rd[3]), 12'h001);
                    if (p) stall_f <= 1'b0;
                    else stall_e <= 1'b0;
                    repeat (2) @(posedge clk);
                    stall_e <= 1'b1;
                    stall_f <= 1'b1;
                    ex = {8'h50 + t[7:0], spr_pkg::spr_tag_t'(t), h == 1 && t > 0, h == 1 && t == 1};
                    chk("tx_byte", p ? got_f : got_e, ex);
                    bus(1'b0, `SPR_IDX_INT_STATUS, 8'h00);
                    chk("tx_empty_int", 12'(rd[4 * p + 1]), 12'h001);
                    bus(1'b1, `SPR_IDX_INT_STATUS, 8'hff);
                end
            end
        end
        $display("t_tx done");
    endtask
    task automatic t_misc;
        bus(1'b1, `SPR_IDX_E_DATA, 8'h11);
        bus(1'b1, `SPR_IDX_E_STATUS, 8'h00);
        chk("tx_full_clr", 12'(tv_e), 12'h000);
        byteenable <= 4'h0;
        bus(1'b1, `SPR_IDX_F_DATA, 8'h22);
        chk("lane_off", 12'(tv_f), 12'h000);
        byteenable <= 4'h1;
        bus(1'b0, 8'h10, 8'h00);
        chk("unmapped", rd[11:0], 12'h000);
        $display("t_misc done");
    endtask
    task automatic t_rx;
        bus(1'b1, `SPR_IDX_INT_MASK, 8'h11);
        spr_far_e_i.offer({8'h3c, 1'b1});
        spr_far_e_i.offer({8'hc3, 1'b0});
        repeat (4) @(posedge clk);
        chk("irq_rx", 12'(irq), 12'h001);
        bus(1'b0, `SPR_IDX_E_STATUS, 8'h00);
        chk("rx_status", rd[11:0], 12'h0c0);
        bus(1'b0, `SPR_IDX_E_ADDR_ONE, 8'h00);
        chk("rx_byte1", rd[11:0], 12'h03c);
        bus(1'b0, `SPR_IDX_E_STATUS, 8'h00);
        chk("rx_next", rd[11:0], 12'h080);
        chk("irq_again", 12'(irq), 12'h001);
        bus(1'b0, `SPR_IDX_E_ADDR_ZERO, 8'h00);
        chk("rx_byte2", rd[11:0], 12'h0c3);
        bus(1'b0, `SPR_IDX_E_STATUS, 8'h00);
        chk("rx_empty", rd[11:0], 12'h000);
        chk("irq_clr", 12'(irq), 12'h000);
        spr_far_f_i.offer({8'ha5, 1'b0});
        repeat (4) @(posedge clk);
        bus(1'b0, `SPR_IDX_F_DATA, 8'h00);
        chk("rx_f", rd[11:0], 12'h0a5);
        ov_e <= 1'b1;
        @(posedge clk);
        ov_e <= 1'b0;
        bus(1'b0, `SPR_IDX_E_STATUS, 8'h00);
        chk("overrun", 12'(rd[5]), 12'h001);
        bus(1'b0, `SPR_IDX_F_STATUS, 8'h00);
        chk("overrun_f", 12'(rd[5]), 12'h001);
        bus(1'b0, `SPR_IDX_E_DATA, 8'h00);
        bus(1'b0, `SPR_IDX_E_STATUS, 8'h00);
        chk("overrun_clr", 12'(rd[5]), 12'h000);
        bus(1'b0, `SPR_IDX_F_DATA, 8'h00);
        bus(1'b0, `SPR_IDX_F_STATUS, 8'h00);
        chk("overrun_f_clr", 12'(rd[5]), 12'h000);
        $display("t_rx done");
    endtask
    initial begin
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        t_tx();
        t_misc();
        t_rx();
        summarize();
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            summarize();
        end
    end
endmodule

`default_nettype wire
